// *** rtl/swss_sideband.sv ***
// Sleep, wake, lamp and card-detect sideband block with an AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module swss_sideband #(
    parameter int unsigned WAKE_PULSE_CYCLES = swss_pkg::WAKE_PULSE_CYC,
    parameter int unsigned LAMP_SLOT_CYCLES = swss_pkg::LAMP_SLOT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Sideband pins
    input wire logic sleep_permit_in,
    output logic sleep_permit_pulldown_en,
    output logic host_wake_out,
    output logic awake_out,
    output logic net_state_lamp_out,
    input wire logic card_present_in,
    output logic card_pullup_en,
    output logic irq
);
    import swss_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic permit_meta_reg;
    logic permit_sync_reg;
    logic card_meta_reg;
    logic card_sync_reg;
    logic card_prev_reg;

    logic dp_wr_reg;
    logic [OFS_W-1:0] dp_ofs_reg;
    logic [31:0] hrdata_reg;

    logic sleep_req_reg;
    swss_net_e net_state_reg;
    swss_pwr_e pwr_reg;
    swss_pwr_e pwr_next;
    logic wake_busy_reg;
    logic [CNT_W-1:0] wake_cnt_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_stat_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            permit_meta_reg <= 1'b0;
            permit_sync_reg <= 1'b0;
            card_meta_reg <= 1'b1;
            card_sync_reg <= 1'b1;
            card_prev_reg <= 1'b1;
        end else begin
            permit_meta_reg <= sleep_permit_in;
            permit_sync_reg <= permit_meta_reg;
            card_meta_reg <= card_present_in;
            card_sync_reg <= card_meta_reg;
            card_prev_reg <= card_sync_reg;
        end
    end

    // Pad pulls: permit floats low, card detect floats high
    assign sleep_permit_pulldown_en = 1'b1;
    assign card_pullup_en = 1'b1;

    // Level high is inserted; edges mark hot insertion and removal
    wire card_present = card_sync_reg;
    wire card_inserted = card_sync_reg & ~card_prev_reg;
    wire card_removed = ~card_sync_reg & card_prev_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // AHB-Lite address and data phase
    wire addr_phase = hsel && htrans[1] && hready;
    wire [OFS_W-1:0] ap_ofs = haddr[OFS_W-1:0];
    wire ap_hit_ctrl = (ap_ofs == REG_CTRL_OFS);
    wire ap_hit_status = (ap_ofs == REG_STATUS_OFS);
    wire ap_hit_istat = (ap_ofs == REG_IRQ_STAT_OFS);
    wire ap_hit_imask = (ap_ofs == REG_IRQ_MASK_OFS);

    wire wr_ctrl = dp_wr_reg && (dp_ofs_reg == REG_CTRL_OFS);
    wire wr_istat = dp_wr_reg && (dp_ofs_reg == REG_IRQ_STAT_OFS);
    wire wr_imask = dp_wr_reg && (dp_ofs_reg == REG_IRQ_MASK_OFS);

    wire is_awake = (pwr_reg == PWR_AWAKE);

    // Read words
    wire [31:0] ctrl_word = {{(32 - CTRL_NET_LSB - NET_W){1'b0}}, net_state_reg, wake_busy_reg, sleep_req_reg};
    wire [31:0] status_word = {28'h000_0000, wake_busy_reg, permit_sync_reg, card_present, is_awake};
    wire [31:0] istat_word = {{(32 - IRQ_W){1'b0}}, irq_stat_reg};
    wire [31:0] imask_word = {{(32 - IRQ_W){1'b0}}, irq_mask_reg};
    wire [31:0] rd_word = ap_hit_ctrl ? ctrl_word :
                          ap_hit_status ? status_word :
                          ap_hit_istat ? istat_word :
                          ap_hit_imask ? imask_word : RD_ZERO;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dp_wr_reg <= 1'b0;
            dp_ofs_reg <= '0;
            hrdata_reg <= RD_ZERO;
        end else begin
            dp_wr_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                dp_ofs_reg <= ap_ofs;
            end
            if (addr_phase && !hwrite) begin
                hrdata_reg <= rd_word;
            end
        end
    end

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Sleep control
    wire permit_high = permit_sync_reg;
    wire may_sleep = sleep_req_reg && !permit_high;
    wire pin_wake = (pwr_reg == PWR_ASLEEP) && permit_high;
    wire sw_wake = (pwr_reg == PWR_ASLEEP) && !sleep_req_reg;

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_AWAKE: begin
                if (may_sleep) begin
                    pwr_next = PWR_ASLEEP;
                end
            end
            PWR_ASLEEP: begin
                if (pin_wake || sw_wake) begin
                    pwr_next = PWR_AWAKE;
                end
            end
        endcase
    end

    wire entering_sleep = is_awake && (pwr_next == PWR_ASLEEP);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_reg <= PWR_AWAKE;
            sleep_req_reg <= 1'b0;
            net_state_reg <= NET_NOSVC;
        end else begin
            pwr_reg <= pwr_next;
            if (wr_ctrl) begin
                sleep_req_reg <= hwdata[CTRL_SLEEP_BIT];
                net_state_reg <= swss_net_e'(hwdata[CTRL_NET_LSB +: NET_W]);
            end else if (pin_wake) begin
                sleep_req_reg <= 1'b0;
            end
        end
    end

    // High only while awake
    assign awake_out = is_awake;

    ////////////////////////////////////////////////////////////////////////////////
    // Host wake pulse
    wire wake_start = wr_ctrl && hwdata[CTRL_HOST_WAKE_BIT] && is_awake && !wake_busy_reg;
    wire wake_done = wake_busy_reg && (wake_cnt_reg == CNT_W'(WAKE_PULSE_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_busy_reg <= 1'b0;
            wake_cnt_reg <= '0;
        end else begin
            if (entering_sleep || wake_done) begin
                wake_busy_reg <= 1'b0;
                wake_cnt_reg <= '0;
            end else if (wake_start) begin
                wake_busy_reg <= 1'b1;
                wake_cnt_reg <= '0;
            end else if (wake_busy_reg) begin
                wake_cnt_reg <= wake_cnt_reg + CNT_W'(1);
            end
        end
    end

    assign host_wake_out = wake_busy_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Lamp pattern
    swss_lamp #(
        .SLOT_CYCLES(LAMP_SLOT_CYCLES)
    ) u_lamp (
        .clk(clk),
        .rst_n(rst_n),
        .net_state(net_state_reg),
        .lamp_out(net_state_lamp_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupts: sticky, write one to clear, new event wins over clear
    wire [IRQ_W-1:0] irq_events = {wake_done, entering_sleep, pin_wake, card_removed, card_inserted};
    wire [IRQ_W-1:0] irq_clear = wr_istat ? hwdata[IRQ_W-1:0] : '0;

    always_comb begin
        irq_stat_next = (irq_stat_reg & ~irq_clear) | irq_events;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= IRQ_MASK_RST;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (wr_imask) begin
                irq_mask_reg <= hwdata[IRQ_W-1:0];
            end
        end
    end

    assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule
`default_nettype wire

// *** rtl/swss_pkg.sv ***
// Constants, register map and state types for the sleep, wake and status sideband block
package swss_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam int unsigned CNT_W = 28;

    // Host wake pulse length
    localparam int unsigned WAKE_PULSE_MS = 1000;
    localparam int unsigned WAKE_PULSE_CYC = WAKE_PULSE_MS * CLK_PER_MS;

    // Lamp patterns, built from slots of one common length
    localparam int unsigned LAMP_SLOT_MS = 100;
    localparam int unsigned LAMP_SLOT_CYC = LAMP_SLOT_MS * CLK_PER_MS;
    localparam int unsigned LAMP_PERIOD_MS = 2000;
    localparam int unsigned NOSVC_LOW1_MS = 100;
    localparam int unsigned NOSVC_HIGH1_MS = 100;
    localparam int unsigned NOSVC_LOW2_MS = 100;
    localparam int unsigned NOSVC_HIGH2_MS = 1700;
    localparam int unsigned REG_LOW_MS = 100;
    localparam int unsigned REG_HIGH_MS = 1900;

    localparam int unsigned SLOT_W = 5;
    localparam logic [SLOT_W-1:0] LAMP_LAST_SLOT = SLOT_W'(LAMP_PERIOD_MS / LAMP_SLOT_MS - 1);
    localparam logic [SLOT_W-1:0] NOSVC_LOW1_END = SLOT_W'(NOSVC_LOW1_MS / LAMP_SLOT_MS);
    localparam logic [SLOT_W-1:0] NOSVC_HIGH1_END = SLOT_W'((NOSVC_LOW1_MS + NOSVC_HIGH1_MS) / LAMP_SLOT_MS);
    localparam logic [SLOT_W-1:0] NOSVC_LOW2_END =
        SLOT_W'((NOSVC_LOW1_MS + NOSVC_HIGH1_MS + NOSVC_LOW2_MS) / LAMP_SLOT_MS);
    localparam logic [SLOT_W-1:0] REG_LOW_END = SLOT_W'(REG_LOW_MS / LAMP_SLOT_MS);

    ////////////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets)
    localparam int unsigned OFS_W = 8;
    localparam logic [OFS_W-1:0] REG_CTRL_OFS = 8'h00;
    localparam logic [OFS_W-1:0] REG_STATUS_OFS = 8'h04;
    localparam logic [OFS_W-1:0] REG_IRQ_STAT_OFS = 8'h08;
    localparam logic [OFS_W-1:0] REG_IRQ_MASK_OFS = 8'h0c;

    // Control fields
    localparam int unsigned CTRL_SLEEP_BIT = 0;
    localparam int unsigned CTRL_HOST_WAKE_BIT = 1;
    localparam int unsigned CTRL_NET_LSB = 2;
    localparam int unsigned NET_W = 2;

    // Status fields
    localparam int unsigned STAT_AWAKE_BIT = 0;
    localparam int unsigned STAT_CARD_BIT = 1;
    localparam int unsigned STAT_WAKE_PIN_BIT = 2;
    localparam int unsigned STAT_HOST_WAKE_BIT = 3;

    // Interrupt status and mask fields
    localparam int unsigned IRQ_W = 5;
    localparam int unsigned IRQ_CARD_IN_BIT = 0;
    localparam int unsigned IRQ_CARD_OUT_BIT = 1;
    localparam int unsigned IRQ_PIN_WAKE_BIT = 2;
    localparam int unsigned IRQ_SLEPT_BIT = 3;
    localparam int unsigned IRQ_HOST_DONE_BIT = 4;

    // Reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        NET_NOSVC = 2'b00,
        NET_REG = 2'b01,
        NET_DIAL = 2'b10,
        NET_RSVD = 2'b11
    } swss_net_e;

    typedef enum logic {
        PWR_AWAKE = 1'b0,
        PWR_ASLEEP = 1'b1
    } swss_pwr_e;

endpackage

// *** rtl/swss_lamp.sv ***
// Lamp pattern generator for the network state indicator
`timescale 1ns/10ps
`default_nettype none
module swss_lamp #(
    parameter int unsigned SLOT_CYCLES = swss_pkg::LAMP_SLOT_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire swss_pkg::swss_net_e net_state,
    output logic lamp_out
);
    import swss_pkg::*;

    logic [CNT_W-1:0] tick_reg;
    logic [SLOT_W-1:0] slot_reg;
    swss_net_e net_prev_reg;
    logic lamp_reg;

    wire state_changed = (net_state != net_prev_reg);
    wire slot_end = (tick_reg == CNT_W'(SLOT_CYCLES - 1));
    wire period_end = slot_end && (slot_reg == LAMP_LAST_SLOT);

    // Low phases of each pattern
    wire nosvc_low = (slot_reg < NOSVC_LOW1_END) ||
                     ((slot_reg >= NOSVC_HIGH1_END) && (slot_reg < NOSVC_LOW2_END));
    wire reg_low = (slot_reg < REG_LOW_END);
    logic lamp_low;

    always_comb begin
        unique case (net_state)
            NET_NOSVC: lamp_low = nosvc_low;
            NET_REG: lamp_low = reg_low;
            NET_DIAL: lamp_low = 1'b1;
            NET_RSVD: lamp_low = nosvc_low;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Slot timing, restarted on any state change
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= '0;
            slot_reg <= '0;
            net_prev_reg <= NET_NOSVC;
            lamp_reg <= 1'b1;
        end else begin
            net_prev_reg <= net_state;
            lamp_reg <= ~lamp_low;
            if (state_changed || slot_end) begin
                tick_reg <= '0;
            end else begin
                tick_reg <= tick_reg + CNT_W'(1);
            end
            if (state_changed || period_end) begin
                slot_reg <= '0;
            end else if (slot_end) begin
                slot_reg <= slot_reg + SLOT_W'(1);
            end
        end
    end

    assign lamp_out = lamp_reg;

endmodule
`default_nettype wire

// *** tb/swss_host_model.sv ***
// Host side model of the sleep-permit pin and the socket card switch
`timescale 1ns/10ps
`default_nettype none
module swss_host_model (
    input wire logic clk,
    input wire logic sleep_permit_pulldown_en,
    input wire logic card_pullup_en,
    output logic sleep_permit_in,
    output logic card_present_in
);
    logic wake_drv = 1'b0;
    logic wake_lvl = 1'b0;
    logic card_drv = 1'b0;
    logic socket_card_switch = 1'b1;
    ////////////////////////////////////////////////////////////////////////////////
    // Released lines go to their pull, else show the inverse of the last level
    assign sleep_permit_in = wake_drv ? wake_lvl : (sleep_permit_pulldown_en ? 1'b0 : !wake_lvl);
    assign card_present_in = card_drv ? socket_card_switch : (card_pullup_en ? 1'b1 : !socket_card_switch);
    // Called right after a rising edge
    task automatic set_pin(input logic drv, input logic lvl);
        {wake_drv, wake_lvl} <= {drv, lvl};
    endtask
    task automatic set_card(input logic drv, input logic lvl);
        {card_drv, socket_card_switch} <= {drv, lvl};
    endtask
endmodule
`default_nettype wire

// *** tb/swss_sideband_asserts.sv ***
// Port checker for the sideband block
`timescale 1ns/10ps
`default_nettype none
module swss_sideband_asserts #(
    parameter int unsigned WAKE_PULSE_CYCLES = swss_pkg::WAKE_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic sleep_permit_in,
    input wire logic sleep_permit_pulldown_en,
    input wire logic host_wake_out,
    input wire logic awake_out,
    input wire logic card_pullup_en
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [31:0] wake_cnt_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_cnt_reg <= 32'h0;
        end else begin
            wake_cnt_reg <= host_wake_out ? wake_cnt_reg + 32'h1 : 32'h0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence pin_rise_s;
        $rose(sleep_permit_in) && !awake_out ##1 sleep_permit_in [*3];
    endsequence
    bus_okay_a: assert property (
        hreadyout && !hresp) else $error("bus answer not ready or not okay");
    pad_pulls_a: assert property (
        sleep_permit_pulldown_en && card_pullup_en) else $error("pad pull enable low");
    sleep_quiet_a: assert property (
        !awake_out |-> !host_wake_out) else $error("host wake high while asleep");
    pin_hold_a: assert property (
        sleep_permit_in [*5] |-> awake_out) else $error("asleep with permit pin high");
    pin_wake_a: assert property (
        pin_rise_s |-> ##[0:2] awake_out) else $error("permit pin rise did not wake");
    sleep_cause_a: assert property (
        $fell(awake_out) |-> !$past(sleep_permit_in, 3)) else $error("slept with pin high");
    wake_len_a: assert property (
        $fell(host_wake_out) && awake_out |-> wake_cnt_reg == WAKE_PULSE_CYCLES) else $error("wake pulse length");
    wake_cause_a: assert property (
        $rose(host_wake_out) |-> $past(hwdata[1])) else $error("host wake without request");
endmodule
bind swss_sideband swss_sideband_asserts #(.WAKE_PULSE_CYCLES(WAKE_PULSE_CYCLES)) u_chk (.clk, .rst_n, .hwdata,
    .hreadyout, .hresp, .sleep_permit_in, .sleep_permit_pulldown_en, .host_wake_out, .awake_out, .card_pullup_en);
`default_nettype wire

// *** tb/swss_sideband_test.sv ***
// Self-checking bench for the sideband block
`timescale 1ns/10ps
`default_nettype none
module swss_sideband_test;
    import swss_pkg::*;
    localparam int unsigned PULSE = 20;
    localparam int unsigned SLOT = 4;
    localparam logic [31:0] A_CTRL = {24'h0, REG_CTRL_OFS};
    localparam logic [31:0] A_STAT = {24'h0, REG_STATUS_OFS};
    localparam logic [31:0] A_IRQ = {24'h0, REG_IRQ_STAT_OFS};
    localparam logic [31:0] A_MASK = {24'h0, REG_IRQ_MASK_OFS};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, sleep_permit_in, sleep_permit_pulldown_en, host_wake_out;
    logic awake_out, net_state_lamp_out, card_present_in, card_pullup_en, irq;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [2:0] pin_vec;
    int failures = 0;
    int cmp_count = 0;
    int n;
    int modes[4] = '{1, 3, 2, 0};
    assign pin_vec = {irq, host_wake_out, awake_out};
    swss_sideband #(.WAKE_PULSE_CYCLES(PULSE), .LAMP_SLOT_CYCLES(SLOT)) dut (.clk, .rst_n, .hsel, .haddr,
        .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .sleep_permit_in,
        .sleep_permit_pulldown_en, .host_wake_out, .awake_out, .net_state_lamp_out, .card_present_in,
        .card_pullup_en, .irq);
    swss_host_model host (.clk, .sleep_permit_pulldown_en, .card_pullup_en, .sleep_permit_in, .card_present_in);
    initial begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Waits for the slave's answer; only the watchdog ends a hung wait
    task automatic hold_ready();
        do begin
            @(posedge clk);
        end while (hreadyout !== 1'b1);
    endtask
    // One single AHB transfer, entered right after a rising edge
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
        hold_ready();
        {hsel, htrans} <= {1'b0, 2'h0};
        if (w) hwdata <= wd;
        hold_ready();
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(rd & m, exp);
    endtask
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check(32'(pin_vec), 32'h1);
        rd_chk(A_STAT, 32'hf, 32'h3);
        rd_chk(A_MASK, 32'h1f, 32'h0);
        rd_chk(A_IRQ, 32'h1f, 32'h0);
        rd_chk(32'h10, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            xfer(A_CTRL, 1'b1, 32'(modes[i]) << 2);
            repeat (3) @(posedge clk);
            for (int k = 0; k < 20; k++) begin
                #1;
                check(32'(net_state_lamp_out), 32'(!(modes[i] == 2 || k == 0 || (modes[i] != 1 && k == 2))));
                repeat (SLOT) @(posedge clk);
            end
        end
        xfer(A_CTRL, 1'b1, 32'h2);
        #1;
        n = 0;
        while (host_wake_out === 1'b1 && n < 100) begin
            n++;
            @(posedge clk);
            #1;
        end
        check(32'(n), 32'(PULSE));
        check(32'(pin_vec), 32'h1);
        rd_chk(A_IRQ, 32'h1f, 32'h10);
        xfer(A_MASK, 1'b1, 32'h10);
        #1;
        check(32'(pin_vec), 32'h5);
        xfer(A_IRQ, 1'b1, 32'h10);
        #1;
        check(32'(pin_vec), 32'h1);
        xfer(A_MASK, 1'b1, 32'h08);
        xfer(A_CTRL, 1'b1, 32'h2);
        xfer(A_CTRL, 1'b1, 32'h1);
        repeat (3) @(posedge clk);
        #1;
        check(32'(pin_vec), 32'h4);
        rd_chk(A_STAT, 32'hf, 32'h2);
        host.set_pin(1'b1, 1'b1);
        repeat (40) @(posedge clk);
        #1;
        check(32'(awake_out), 32'h1);
        xfer(A_CTRL, 1'b1, 32'h1);
        repeat (8) @(posedge clk);
        #1;
        check(32'(awake_out), 32'h1);
        rd_chk(A_IRQ, 32'h4, 32'h4);
        host.set_pin(1'b0, 1'b0);
        xfer(A_IRQ, 1'b1, 32'h1f);
        host.set_card(1'b1, 1'b0);
        repeat (5) @(posedge clk);
        rd_chk(A_STAT, 32'h2, 32'h0);
        rd_chk(A_IRQ, 32'h3, 32'h2);
        host.set_card(1'b1, 1'b1);
        repeat (5) @(posedge clk);
        rd_chk(A_IRQ, 32'h3, 32'h3);
        rd_chk(A_STAT, 32'h2, 32'h2);
        #1;
        check(32'(pin_vec), 32'h4);
        xfer(A_CTRL, 1'b1, 32'h0);
        @(posedge clk);
        #1;
        check(32'(awake_out), 32'h1);
        complete_run();
    end
endmodule
`default_nettype wire
